// [logic/threshold_crossing_irq_config.sv]
// Purpose: Crossing interrupt configuration, threshold pair storage and event status.
// Assumes: APB slave, zero wait states; samples arrive with one-cycle strobes.
// Notes: Detector k uses enable bits 2k+1:2k and sets status bit k.
//
// Operation
// R1: Selector 00 raises no interrupt for that threshold in either direction.
// R2: Selector 01 raises an interrupt only on a move from at-or-below to above.
// R3: Selector 10 raises an interrupt only on a move from above to at-or-below.
// R4: Selector 11 raises an interrupt on every crossing in either direction.
// R5: Channel 22 field is bits 5:0, pairs for level-3 thresholds a, b, c.
// R6: Channel 23 field is bits 15:6, pairs for a, b, c, threshold 8 and 9.
// R7: The top pair of the channel 23 field governs threshold 9 with the same code.
// R8: Bits 19:16 select edges for supply set 0 thresholds a (low) and b (high).
// R9: Bits 23:20 select edges for supply set 1 thresholds a (low) and b (high).
// R10: Threshold 0 is a 10-bit read-write value in bits 9:0.
// R11: Threshold 1 is a 10-bit read-write value in bits 19:10.
// R12: An edge is flagged only when the above-threshold result differs from the last one.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "threshold_crossing_irq_regs.svh"
module threshold_crossing_irq_config #(
    parameter int sample_width = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic channel22_sample_valid,
    input wire logic [sample_width-1:0] switch_channel_22,
    input wire logic channel23_sample_valid,
    input wire logic [sample_width-1:0] switch_channel_23,
    input wire logic supply_sample_valid,
    input wire logic [sample_width-1:0] supply_sample,
    input wire logic [sample_width-1:0] level3_threshold_a,
    input wire logic [sample_width-1:0] level3_threshold_b,
    input wire logic [sample_width-1:0] level3_threshold_c,
    input wire logic [sample_width-1:0] threshold_value_8,
    input wire logic [sample_width-1:0] threshold_value_9,
    input wire logic [sample_width-1:0] supply_set0_threshold_a,
    input wire logic [sample_width-1:0] supply_set0_threshold_b,
    input wire logic [sample_width-1:0] supply_set1_threshold_a,
    input wire logic [sample_width-1:0] supply_set1_threshold_b,
    output logic [sample_width-1:0] threshold_value_0,
    output logic [sample_width-1:0] threshold_value_1,
    output logic irq
);

    localparam int event_count = `EVENT_COUNT;

    // ------------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------------
    logic [`ENABLE_WIDTH-1:0] enable_q;
    logic [`THRESHOLD_PAIR_WIDTH-1:0] threshold_pair_q;
    logic [event_count-1:0] status_q;
    logic [event_count-1:0] mask_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic [9:0] word_index;
    logic setup_phase;
    logic write_access;
    logic hit_enable;
    logic hit_threshold;
    logic hit_status;
    logic hit_mask;
    logic hit_any;

    assign word_index = paddr[11:2];
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite;
    assign hit_enable = word_index == `CROSSING_IRQ_ENABLE_4_INDEX;
    assign hit_threshold = word_index == `THRESHOLD_VALUE_PAIR_0_INDEX;
    assign hit_status = word_index == `CROSSING_IRQ_STATUS_INDEX;
    assign hit_mask = word_index == `CROSSING_IRQ_MASK_INDEX;
    assign hit_any = hit_enable || hit_threshold || hit_status || hit_mask;

    // Zero wait states: read data is captured in setup, so access completes at once.
    assign pready = 1'b1;

    // ------------------------------------------------------------------------
    // Edge selector register
    // ------------------------------------------------------------------------

    // R5: channel 22 pairs. R6: channel 23 pairs. R8: supply set 0. R9: supply set 1.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= `ENABLE_RESET;
        end else if (write_access && hit_enable) begin
            enable_q <= pwdata[`ENABLE_WIDTH-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Threshold pair register
    // ------------------------------------------------------------------------

    // R10: threshold 0 low field. R11: threshold 1 high field; bits above read zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            threshold_pair_q <= `THRESHOLD_PAIR_RESET;
        end else if (write_access && hit_threshold) begin
            threshold_pair_q <= pwdata[`THRESHOLD_PAIR_WIDTH-1:0];
        end
    end

    assign threshold_value_0 = threshold_pair_q[`THRESHOLD_0_LSB +: sample_width];
    assign threshold_value_1 = threshold_pair_q[`THRESHOLD_1_LSB +: sample_width];

    // ------------------------------------------------------------------------
    // Detector inputs
    // ------------------------------------------------------------------------
    logic [sample_width-1:0] det_threshold [event_count];
    logic [sample_width-1:0] det_sample [event_count];
    logic [event_count-1:0] det_valid;
    logic [event_count-1:0] det_event;

    // Threshold of each detector, in the order of the selector pairs.
    assign det_threshold[0] = level3_threshold_a;
    assign det_threshold[1] = level3_threshold_b;
    assign det_threshold[2] = level3_threshold_c;
    assign det_threshold[3] = level3_threshold_a;
    assign det_threshold[4] = level3_threshold_b;
    assign det_threshold[5] = level3_threshold_c;
    assign det_threshold[6] = threshold_value_8;
    // R7: top channel 23 pair watches threshold 9.
    assign det_threshold[7] = threshold_value_9;
    assign det_threshold[8] = supply_set0_threshold_a;
    assign det_threshold[9] = supply_set0_threshold_b;
    assign det_threshold[10] = supply_set1_threshold_a;
    assign det_threshold[11] = supply_set1_threshold_b;

    // ------------------------------------------------------------------------
    // Crossing detectors
    // ------------------------------------------------------------------------

    // Detectors 0-2 watch channel 22, 3-7 channel 23, 8-11 the supply.
    for (genvar k = 0; k < event_count; k++) begin : g_detector
        if (k < 3) begin : g_ch22
            assign det_sample[k] = switch_channel_22;
            assign det_valid[k] = channel22_sample_valid;
        end else if (k < 8) begin : g_ch23
            assign det_sample[k] = switch_channel_23;
            assign det_valid[k] = channel23_sample_valid;
        end else begin : g_supply
            assign det_sample[k] = supply_sample;
            assign det_valid[k] = supply_sample_valid;
        end

        // R1 R2 R3 R4: pair k of the selector register qualifies detector k.
        crossing_detector #(
            .sample_width(sample_width)
        ) u_detector (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(det_valid[k]),
            .sample(det_sample[k]),
            .threshold(det_threshold[k]),
            .edge_select(enable_q[2*k +: 2]),
            .crossing(det_event[k])
        );
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------

    // Sticky status, write one to clear; a new event in the clear cycle wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= `EVENT_RESET;
        end else if (write_access && hit_status) begin
            status_q <= (status_q & ~pwdata[event_count-1:0]) | det_event;
        end else begin
            status_q <= status_q | det_event;
        end
    end

    // A set mask bit lets the matching status bit reach the interrupt line.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= `EVENT_RESET;
        end else if (write_access && hit_mask) begin
            mask_q <= pwdata[event_count-1:0];
        end
    end

    // Level output; it stays high while any status bit has its mask bit set.
    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------------------
    // Read data and error
    // ------------------------------------------------------------------------

    // Read data is sampled in the setup cycle so it stands stable through access.
    // Status read here may lag an event landing in the access cycle by one read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `READ_ZERO;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= `READ_ZERO;
            if (hit_enable) begin
                prdata_q[`ENABLE_WIDTH-1:0] <= enable_q;
            end else if (hit_threshold) begin
                prdata_q[`THRESHOLD_PAIR_WIDTH-1:0] <= threshold_pair_q;
            end else if (hit_status) begin
                prdata_q[event_count-1:0] <= status_q;
            end else if (hit_mask) begin
                prdata_q[event_count-1:0] <= mask_q;
            end
        end
    end

    // Unmapped addresses answer with an error in the access cycle; writes there are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= !hit_any;
        end else if (!psel) begin
            pslverr_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

endmodule : threshold_crossing_irq_config

// [inc/threshold_crossing_irq_regs.svh]
// Purpose: Register indices, field positions and reset values of the crossing block.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only; included by bare name.
`ifndef THRESHOLD_CROSSING_IRQ_REGS_SVH
`define THRESHOLD_CROSSING_IRQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define CROSSING_IRQ_ENABLE_4_INDEX 10'h028
`define THRESHOLD_VALUE_PAIR_0_INDEX 10'h029
`define CROSSING_IRQ_STATUS_INDEX 10'h030
`define CROSSING_IRQ_MASK_INDEX 10'h031

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define ENABLE_WIDTH 24
`define ENABLE_RESET 24'h00_0000
`define THRESHOLD_PAIR_WIDTH 20
`define THRESHOLD_PAIR_RESET 20'h0_0000
`define THRESHOLD_0_LSB 0
`define THRESHOLD_1_LSB 10
`define EVENT_COUNT 12
`define EVENT_RESET 12'h000
`define READ_ZERO 32'h0000_0000

`endif

// [inc/threshold_crossing_irq_pkg.sv]
// Purpose: Types shared by the crossing block and its detector.
// Assumes: Two-bit edge selector encoding of none, rising, falling, both.
// Notes: No constants other than the enumeration codes.
package threshold_crossing_irq_pkg;

    // ------------------------------------------------------------------------
    // Edge selector encoding
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        edge_none = 2'b00,
        edge_rising = 2'b01,
        edge_falling = 2'b10,
        edge_both = 2'b11
    } edge_select_type;

endpackage : threshold_crossing_irq_pkg

// [logic/crossing_detector.sv]
// Purpose: Detects one threshold crossing and qualifies it by a two-bit edge selector.
// Assumes: A sample is presented with a one-cycle valid strobe.
// Notes: The first sample after reset only primes the history and never fires.
`timescale 1ns/1ps
module crossing_detector #(
    parameter int sample_width = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic [sample_width-1:0] sample,
    input wire logic [sample_width-1:0] threshold,
    input wire logic [1:0] edge_select,
    output logic crossing
);

    logic above;
    logic above_q;
    logic primed_q;
    logic crossing_q;
    logic rose;
    logic fell;
    logic fire;

    // ------------------------------------------------------------------------
    // Crossing classification
    // ------------------------------------------------------------------------

    // R12: compare with history. At-or-below counts as not above.
    assign above = sample > threshold;
    assign rose = primed_q && above && !above_q;
    assign fell = primed_q && !above && above_q;

    // Selector decode; a cast keeps the case on the named encodings.
    always_comb begin
        case (threshold_crossing_irq_pkg::edge_select_type'(edge_select))
            // R1: none selected.
            threshold_crossing_irq_pkg::edge_none: fire = 1'b0;
            // R2: rising only.
            threshold_crossing_irq_pkg::edge_rising: fire = rose;
            // R3: falling only.
            threshold_crossing_irq_pkg::edge_falling: fire = fell;
            // R4: both directions.
            threshold_crossing_irq_pkg::edge_both: fire = rose || fell;
            default: fire = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // History and event flop
    // ------------------------------------------------------------------------

    // History is kept whatever the selector, so enabling later never sees stale state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            above_q <= 1'b0;
            primed_q <= 1'b0;
        end else if (sample_valid) begin
            above_q <= above;
            primed_q <= 1'b1;
        end
    end

    // Event is a one-cycle pulse the cycle after the qualifying sample.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crossing_q <= 1'b0;
        end else begin
            crossing_q <= sample_valid && fire;
        end
    end

    assign crossing = crossing_q;

endmodule : crossing_detector

// [testbench/apb_host.sv]
// Purpose: APB master standing in for the host controller.
// Assumes: One transfer at a time, driven just after rising edges.
// Notes: Waits for pready with no limit of its own; the bench watchdog ends a hang.
`timescale 1ns/1ps
module apb_host (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    // ------
    // Bus idle at time zero
    // ------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // Setup, then access held until pready is seen high at an edge.
    task automatic xfer(logic w, logic [11:0] a, logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host

// [testbench/crossing_irq_monitor.sv]
// Purpose: Port-level checks of the crossing interrupt block.
// Assumes: Zero-wait APB; byte address is four times the index.
// Notes: Enable is shadowed from observed writes, as the body is hidden.
`timescale 1ns/1ps
`include "threshold_crossing_irq_regs.svh"
module crossing_irq_monitor #(
    parameter int sample_width = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic channel22_sample_valid,
    input wire logic channel23_sample_valid,
    input wire logic supply_sample_valid,
    input wire logic [sample_width-1:0] threshold_value_0,
    input wire logic [sample_width-1:0] threshold_value_1,
    input wire logic irq
);
    // ------
    // Decode and shadow
    // ------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [9:0] ix;
    logic acc, wr, rd, rs, mw, vld, mapped;
    logic [23:0] en_q;
    // Access kinds seen on the bus.
    assign ix = paddr[11:2];
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign rs = psel && !penable && !pwrite;
    assign mw = wr && ix == `CROSSING_IRQ_MASK_INDEX;
    assign vld = channel22_sample_valid || channel23_sample_valid || supply_sample_valid;
    assign mapped = ix inside {`CROSSING_IRQ_ENABLE_4_INDEX, `THRESHOLD_VALUE_PAIR_0_INDEX,
        `CROSSING_IRQ_STATUS_INDEX, `CROSSING_IRQ_MASK_INDEX};
    // Shadow of the enable word, so reads can be judged without the body.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= `ENABLE_RESET;
        end else if (wr && ix == `CROSSING_IRQ_ENABLE_4_INDEX) begin
            en_q <= pwdata[23:0];
        end
    end

    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_thr_load: assert property (
        wr && ix == `THRESHOLD_VALUE_PAIR_0_INDEX |=> threshold_value_0 == $past(pwdata[9:0])
        && threshold_value_1 == $past(pwdata[19:10]))
        else $error("threshold pair not loaded");
    a_rd_pair: assert property (
        rd && ix == `THRESHOLD_VALUE_PAIR_0_INDEX
        |-> prdata == {12'h000, threshold_value_1, threshold_value_0})
        else $error("threshold pair read wrong");
    a_rd_enable: assert property (
        rd && ix == `CROSSING_IRQ_ENABLE_4_INDEX |-> prdata == {8'h00, en_q})
        else $error("enable read wrong");
    a_prd_hold: assert property (!$past(rs) |-> $stable(prdata))
        else $error("read data moved outside a read");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(mw) || $past(mw, 2) || ($past(vld, 2) && $past(en_q, 2) != 0)
        || ($past(vld, 3) && $past(en_q, 3) != 0))
        else $error("interrupt rose without cause");
    a_mask_off: assert property (mw && pwdata[11:0] == 12'h000 |-> ##2 !irq)
        else $error("interrupt high with mask clear");

    // Main scenarios reached.
    c_irq: cover property ($rose(irq));
    c_err: cover property (acc && !mapped);
    c_mask: cover property (mw);
endmodule : crossing_irq_monitor

bind threshold_crossing_irq_config crossing_irq_monitor #(.sample_width(sample_width)) mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .channel22_sample_valid, .channel23_sample_valid, .supply_sample_valid,
    .threshold_value_0, .threshold_value_1, .irq
);

// [testbench/tb.sv]
// Purpose: Self-checking bench for the crossing interrupt block.
// Assumes: Only the channel and threshold of the detector under test move.
// Notes: Idle thresholds sit at full scale and idle samples at zero, so miswiring shows.
`timescale 1ns/1ps
`include "threshold_crossing_irq_regs.svh"
module tb;
    localparam logic [11:0] en_a = {`CROSSING_IRQ_ENABLE_4_INDEX, 2'b00};
    localparam logic [11:0] st_a = {`CROSSING_IRQ_STATUS_INDEX, 2'b00};
    localparam logic [11:0] mk_a = {`CROSSING_IRQ_MASK_INDEX, 2'b00};
    localparam logic [11:0] ad [4] = '{en_a, {`THRESHOLD_VALUE_PAIR_0_INDEX, 2'b00}, st_a, mk_a};
    localparam logic [31:0] wm [4] = '{32'h00ff_ffff, 32'h000f_ffff, '0, 32'h0000_0fff};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, sv;
    logic [11:0] paddr, mk, ex;
    logic [31:0] pwdata, prdata, rv;
    logic [31:0] wd [4];
    logic [9:0] t, tv0, tv1;
    logic [9:0] smp [3];
    logic [9:0] th [9];
    int error_cnt, num_checks;

    threshold_crossing_irq_config dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .channel22_sample_valid(sv), .switch_channel_22(smp[0]),
        .channel23_sample_valid(sv), .switch_channel_23(smp[1]), .supply_sample_valid(sv),
        .supply_sample(smp[2]), .level3_threshold_a(th[0]), .level3_threshold_b(th[1]),
        .level3_threshold_c(th[2]), .threshold_value_8(th[3]), .threshold_value_9(th[4]),
        .supply_set0_threshold_a(th[5]), .supply_set0_threshold_b(th[6]),
        .supply_set1_threshold_a(th[7]), .supply_set1_threshold_b(th[8]),
        .threshold_value_0(tv0), .threshold_value_1(tv1), .irq
    );
    apb_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata);

    // ------
    // Helpers
    // ------
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(logic [11:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d, rv, er);
    endtask : wr
    task automatic rd(logic [11:0] a);
        host.xfer(1'b0, a, '0, rv, er);
    endtask : rd
    // One strobe with value v on channel c and zero elsewhere, then time to settle.
    task automatic send(int c, logic [9:0] v);
        @(posedge pclk);
        for (int j = 0; j < 3; j++) begin
            smp[j] <= (j == c) ? v : 10'h000;
        end
        sv <= 1'b1;
        @(posedge pclk);
        sv <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : send
    // Status bit that detector k should set for this selector and direction.
    function automatic logic [11:0] fire(int k, logic [1:0] s, logic up);
        return (up ? s[0] : s[1]) ? 12'h001 << k : 12'h000;
    endfunction : fire
    // Threshold input and channel that the selector pair of detector k is bound to.
    function automatic int thr_of(int k);
        return (k < 6) ? k % 3 : k - 3;
    endfunction : thr_of
    function automatic int ch_of(int k);
        return (k < 3) ? 0 : ((k < 8) ? 1 : 2);
    endfunction : ch_of
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Clock and watchdog; the run needs about 2100 cycles.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #1_000_000;
        error_cnt++;
        summarize();
    end

    // Main sequence.
    initial begin
        presetn = 1'b0;
        {sv, error_cnt, num_checks} = '0;
        smp = '{default: 10'h000};
        th = '{default: 10'h000};
        rv = $urandom(32'h0000_626d);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(ad[i]);
            chk("reset", '0, rv);
            wd[i] = $urandom;
            wr(ad[i], wd[i]);
            rd(ad[i]);
            chk("readback", wd[i] & wm[i], rv);
            chk("err_ok", '0, 32'(er));
        end
        chk("thr0", 32'(wd[1][9:0]), 32'(tv0));
        chk("thr1", 32'(wd[1][19:10]), 32'(tv1));
        wr(12'h100, $urandom);
        chk("err_wr", 32'h1, 32'(er));
        rd(12'h100);
        chk("err_rd", 32'h1, 32'(er));
        chk("unmapped", '0, rv);
        rd(en_a);
        chk("enable_kept", wd[0] & wm[0], rv);
        wr(en_a, '0);
        // Every selector code on every detector; equal sample is the low side.
        for (int k = 0; k < 12; k++) begin
            for (int s = 0; s < 4; s++) begin
                t = 10'($urandom_range(1022, 1));
                mk = 12'($urandom);
                @(posedge pclk);
                for (int j = 0; j < 9; j++) begin
                    th[j] <= (j == thr_of(k)) ? t : 10'h3ff;
                end
                send(ch_of(k), t);
                wr(en_a, 32'(s) << (2 * k));
                wr(mk_a, 32'(mk));
                send(ch_of(k), t + 10'h001);
                ex = fire(k, s[1:0], 1'b1);
                rd(st_a);
                chk("rise", 32'(ex), rv);
                send(ch_of(k), t);
                ex = ex | fire(k, s[1:0], 1'b0);
                rd(st_a);
                chk("fall", 32'(ex), rv);
                chk("irq", 32'(|(ex & mk)), 32'(irq));
                wr(st_a, 32'h0000_0fff);
                wr(en_a, '0);
                wr(mk_a, '0);
                rd(st_a);
                chk("clear", '0, rv);
            end
        end
        summarize();
    end
endmodule : tb
